// >>> inc/router_pkg.sv
// Constants, tables and carrier types for the interrupt activation router.
// Assumes one 200 MHz clock and on-chip source flags on that same clock.
package router_pkg;

    // Source count, DMA channel count and transfer enable register count
    localparam int NSRC   = 39;
    localparam int NCHAN  = 4;
    localparam int NENA   = 6;
    localparam int SRC_W  = 6;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFF_ENA    = 8'h00;
    localparam logic [7:0] OFF_SWVEC  = 8'h18;
    localparam logic [7:0] OFF_DMACH  = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h2c;
    localparam logic [7:0] OFF_STEP   = 8'h04;

    // Field positions
    localparam int SWVEC_LSB    = 0;
    localparam int SWVEC_W      = 7;
    localparam int SWVEC_PEND   = 7;
    localparam int DMA_SEL_LSB  = 0;
    localparam int DMA_SEL_W    = 4;
    localparam int DMA_CLAIM    = 4;
    localparam int ST_BUSY      = 0;
    localparam int ST_SWPEND    = 1;
    localparam int ST_SRC_LSB   = 8;

    // Reset values
    localparam logic [47:0] ENA_RESET   = 48'h0000_0000_0000;
    localparam logic [6:0]  SWVEC_RESET = 7'h00;
    localparam logic [3:0]  SEL_RESET   = 4'h0;

    // Transfer unit vector address base
    localparam logic [15:0] VA_BASE = 16'h0400;

    // Cycles to wait after a transfer so a cleared flag has dropped
    localparam int          SETTLE_NS     = 10;
    localparam int          CLK_PERIOD_NS = 5;
    localparam logic [1:0]  SETTLE_CYCLES =
        2'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Vector numbers in default order, highest first
    localparam logic [6:0] VEC_NUM [0:NSRC-1] = '{
        7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
        7'h1c,
        7'h20, 7'h21, 7'h22, 7'h23, 7'h28, 7'h29, 7'h2c, 7'h2d,
        7'h30, 7'h31, 7'h32, 7'h33, 7'h38, 7'h39, 7'h3c, 7'h3d,
        7'h40, 7'h41, 7'h44, 7'h45,
        7'h48, 7'h49, 7'h4a, 7'h4b,
        7'h51, 7'h52, 7'h55, 7'h56, 7'h59, 7'h5a
    };

    // Position of each source's enable bit in the 48-bit enable vector
    localparam logic [5:0] ENA_BIT [0:NSRC-1] = '{
        6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00,
        6'h0e,
        6'h0d, 6'h0c, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h17, 6'h16,
        6'h15, 6'h14, 6'h13, 6'h12, 6'h11, 6'h10, 6'h1d, 6'h1c,
        6'h1b, 6'h1a, 6'h19, 6'h18,
        6'h27, 6'h26, 6'h25, 6'h24,
        6'h23, 6'h22, 6'h21, 6'h20, 6'h2f, 6'h2e
    };

    // Enable bits that have a source; the rest store nothing
    localparam logic [47:0] ENA_VALID = 48'hc0ff_3fff_7fff;

    // Sources whose flag the peripheral clears on data register access
    localparam logic [NSRC-1:0] PERIPH_CLR = 39'h7e_0000_0100;

    // DMA source-select code to source index; 6'h3f means no source
    localparam logic [5:0] DMA_SRC_MAP [0:15] = '{
        6'h3f, 6'h08, 6'h09, 6'h0d, 6'h0f, 6'h11, 6'h15, 6'h17,
        6'h21, 6'h22, 6'h23, 6'h24, 6'h3f, 6'h3f, 6'h3f, 6'h3f
    };

    // Transfer unit states
    typedef enum logic [1:0] {
        XF_IDLE   = 2'b00,
        XF_BUSY   = 2'b01,
        XF_SETTLE = 2'b10
    } xfer_state_e;

    // Completion report from the transfer unit
    typedef struct packed {
        logic done;
        logic postIrq;
        logic countZero;
    } xfer_done_s;

    // Per-channel DMA routing setup
    typedef struct packed {
        logic       claim;
        logic [3:0] select;
    } dma_cfg_s;

endpackage : router_pkg

// >>> verilog/first_set_picker.sv
// Fixed-order picker: lowest set index of a request vector wins.
// Assumes a combinational use by a clocked owner on the same clock.
`timescale 1ns/1ps
module first_set_picker #(
    parameter int WIDTH = 39,
    parameter int IDX_W = 6
) (
    input  wire logic [WIDTH-1:0] req,
    output logic                  found,
    output logic [IDX_W-1:0]      index
);

    logic [WIDTH:0]   lowerAny;
    logic [WIDTH-1:0] winner;

    // Chain marking whether any higher-priority bit is set
    assign lowerAny[0] = 1'b0;
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : gChain
        assign winner[g]     = req[g] & ~lowerAny[g];
        assign lowerAny[g+1] = lowerAny[g] | req[g];
    end

    assign found = lowerAny[WIDTH];

    // Encode the one-hot winner
    always_comb begin
        index = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (winner[i]) begin
                index = IDX_W'(i);
            end
        end
    end

endmodule : first_set_picker

// >>> verilog/interrupt_transfer_activation_router.sv
// Routes interrupt source flags to the CPU, transfer unit and DMA channels.
// Assumes source flags, completions and the bus share ref_clk; rst is synchronous.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

// Contract
// - Requests route to CPU, transfer unit, DMA
// - DMA channel source chosen by select field
// - Claimed source never reaches transfer unit/CPU
// - Enable bit picks transfer unit or CPU
// - Post-transfer bit clears enable, forwards CPU
// - Count zero clears enable, forwards CPU
// - Transfer unit picks by fixed default order
// - Software vector write wins, base plus vector*2
// - Hardware vector address is base plus twice
// - Converter end usable, vector 28
// - DMA completions usable, vectors 72 to 75
// - Serial events usable, lowest default order
// - Transfer finishes before CPU sees source
// - DMA proceeds independently of other consumers
// - Unclaimed DMA use leaves flag alone
// - Enable without post bit: unit clears flag
// - Claimed source used and cleared by DMA
// - Serial, converter flags cleared by peripheral
module interrupt_transfer_activation_router (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic [7:0]                    address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [31:0]                   writedata,
    output logic [31:0]                        readdata,
    output logic                               waitrequest,
    input  wire logic [router_pkg::NSRC-1:0]   srcReq,
    output logic [router_pkg::NSRC-1:0]        srcClear,
    output logic [router_pkg::NSRC-1:0]        cpuReq,
    output logic                               xferReq,
    output logic [15:0]                        xferVector,
    output logic                               xferSoftware,
    input  wire router_pkg::xfer_done_s        xferDone,
    output logic [router_pkg::NCHAN-1:0]       dmaReq,
    input  wire logic [router_pkg::NCHAN-1:0]  dmaDone
);

    localparam int NSRC  = router_pkg::NSRC;
    localparam int NCHAN = router_pkg::NCHAN;
    localparam int SRC_W = router_pkg::SRC_W;

    router_pkg::xfer_state_e    state;
    router_pkg::dma_cfg_s       dmaCfg [NCHAN];
    logic [47:0]                enaBits;
    logic [6:0]                 swVector;
    logic                       swPending;
    logic [SRC_W-1:0]           curSrc;
    logic [1:0]                 settleCnt;
    logic [NSRC-1:0]            claimed;
    logic [NSRC-1:0]            dtceVec;
    logic [NSRC-1:0]            eligible;
    logic [NSRC-1:0]            next_srcClear;
    logic [SRC_W-1:0]           chanSrc [NCHAN];
    logic [NCHAN-1:0]           chanValid;
    logic                       pickFound;
    logic [SRC_W-1:0]           pickIdx;
    logic                       wrHit;
    logic                       hwDone;
    logic                       enaClear;
    logic                       flagClear;

    // Bus write takes effect on the cycle waitrequest is low
    assign wrHit = write & ~waitrequest;

    // Completion of a hardware-sourced transfer
    assign hwDone   = (state == router_pkg::XF_BUSY) & xferDone.done & ~xferSoftware;
    assign enaClear = hwDone & (xferDone.postIrq | xferDone.countZero);
    assign flagClear = hwDone & ~xferDone.postIrq & ~xferDone.countZero;

    // Per-channel source decode
    genvar c;
    for (c = 0; c < NCHAN; c++) begin : gChan
        assign chanSrc[c]   = router_pkg::DMA_SRC_MAP[dmaCfg[c].select];
        assign chanValid[c] = chanSrc[c] < SRC_W'(NSRC);
    end

    // Per-source routing terms
    genvar s;
    for (s = 0; s < NSRC; s++) begin : gSrc
        logic claimHit;
        logic dmaClr;
        always_comb begin
            claimHit = 1'b0;
            dmaClr   = 1'b0;
            for (int k = 0; k < NCHAN; k++) begin
                if (chanValid[k] && dmaCfg[k].claim && chanSrc[k] == SRC_W'(s)) begin
                    claimHit = 1'b1;
                    dmaClr   = dmaClr | dmaDone[k];
                end
            end
        end
        assign claimed[s]  = claimHit;
        assign dtceVec[s]  = enaBits[router_pkg::ENA_BIT[s]];
        assign eligible[s] = srcReq[s] & ~claimed[s] & dtceVec[s];
        // A hardware transfer completing with neither post bit nor count zero, or a claimed channel's completion, clears; peripherals clear their own
        assign next_srcClear[s] = ~router_pkg::PERIPH_CLR[s] &
            ((flagClear & curSrc == SRC_W'(s)) | dmaClr);
    end

    // Fixed default order across all hardware sources
    first_set_picker #(
        .WIDTH (NSRC),
        .IDX_W (SRC_W)
    ) u_picker (
        .req   (eligible),
        .found (pickFound),
        .index (pickIdx)
    );

    // Avalon-MM handshake: one wait cycle, then answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
            if ((read | write) & waitrequest) begin
                readdata <= 32'h0000_0000;
                for (int r = 0; r < router_pkg::NENA; r++) begin
                    if (address == 8'(router_pkg::OFF_ENA + r * router_pkg::OFF_STEP)) begin
                        readdata[7:0] <= enaBits[r*8 +: 8];
                    end
                end
                for (int k = 0; k < NCHAN; k++) begin
                    if (address == 8'(router_pkg::OFF_DMACH + k * router_pkg::OFF_STEP)) begin
                        readdata[router_pkg::DMA_SEL_LSB +: router_pkg::DMA_SEL_W] <=
                            dmaCfg[k].select;
                        readdata[router_pkg::DMA_CLAIM] <= dmaCfg[k].claim;
                    end
                end
                if (address == router_pkg::OFF_SWVEC) begin
                    readdata[router_pkg::SWVEC_LSB +: router_pkg::SWVEC_W] <= swVector;
                    readdata[router_pkg::SWVEC_PEND] <= swPending;
                end
                if (address == router_pkg::OFF_STATUS) begin
                    readdata[router_pkg::ST_BUSY]   <= state != router_pkg::XF_IDLE;
                    readdata[router_pkg::ST_SWPEND] <= swPending;
                    readdata[router_pkg::ST_SRC_LSB +: SRC_W] <= curSrc;
                end
            end
        end
    end

    // Transfer enable bits: software writes, hardware clears after a post-bit or count-zero transfer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enaBits <= router_pkg::ENA_RESET;
        end else begin
            for (int r = 0; r < router_pkg::NENA; r++) begin
                if (wrHit && address == 8'(router_pkg::OFF_ENA + r * router_pkg::OFF_STEP)) begin
                    // Bits with no source never store a one
                    enaBits[r*8 +: 8] <= writedata[7:0] & router_pkg::ENA_VALID[r*8 +: 8];
                end
            end
            if (enaClear) begin
                enaBits[router_pkg::ENA_BIT[curSrc]] <= 1'b0;
            end
        end
    end

    // DMA channel routing setup
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int k = 0; k < NCHAN; k++) begin
                dmaCfg[k] <= '{claim: 1'b0, select: router_pkg::SEL_RESET};
            end
        end else begin
            for (int k = 0; k < NCHAN; k++) begin
                if (wrHit && address == 8'(router_pkg::OFF_DMACH + k * router_pkg::OFF_STEP)) begin
                    dmaCfg[k].select <= writedata[router_pkg::DMA_SEL_LSB +: router_pkg::DMA_SEL_W];
                    dmaCfg[k].claim  <= writedata[router_pkg::DMA_CLAIM];
                end
            end
        end
    end

    // Software activation: a new write wins over completion clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            swVector  <= router_pkg::SWVEC_RESET;
            swPending <= 1'b0;
        end else begin
            if ((state == router_pkg::XF_BUSY) && xferDone.done && xferSoftware) begin
                swPending <= 1'b0;
            end
            if (wrHit && address == router_pkg::OFF_SWVEC) begin
                swVector  <= writedata[router_pkg::SWVEC_LSB +: router_pkg::SWVEC_W];
                swPending <= 1'b1;
            end
        end
    end

    // Transfer unit sequencer: pick, hold until done, settle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state        <= router_pkg::XF_IDLE;
            xferReq      <= 1'b0;
            xferVector   <= 16'h0000;
            xferSoftware <= 1'b0;
            curSrc       <= '0;
            settleCnt    <= 2'b00;
        end else begin
            case (state)
                router_pkg::XF_IDLE: begin
                    if (swPending) begin
                        state        <= router_pkg::XF_BUSY;
                        xferReq      <= 1'b1;
                        xferSoftware <= 1'b1;
                        xferVector   <= router_pkg::VA_BASE + {8'h00, swVector, 1'b0};
                    end else if (pickFound) begin
                        state        <= router_pkg::XF_BUSY;
                        xferReq      <= 1'b1;
                        xferSoftware <= 1'b0;
                        curSrc       <= pickIdx;
                        // Covers converter, DMA completion and serial vectors
                        xferVector   <= router_pkg::VA_BASE +
                            {8'h00, router_pkg::VEC_NUM[pickIdx], 1'b0};
                    end
                end
                router_pkg::XF_BUSY: begin
                    // Request stands until the unit reports completion
                    if (xferDone.done) begin
                        state     <= router_pkg::XF_SETTLE;
                        xferReq   <= 1'b0;
                        settleCnt <= router_pkg::SETTLE_CYCLES;
                    end
                end
                router_pkg::XF_SETTLE: begin
                    if (settleCnt <= 2'b01) begin
                        state <= router_pkg::XF_IDLE;
                    end
                    settleCnt <= settleCnt - 2'b01;
                end
                default: begin
                    state   <= router_pkg::XF_IDLE;
                    xferReq <= 1'b0;
                end
            endcase
        end
    end

    // CPU path: unclaimed sources whose enable bit is clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpuReq <= '0;
        end else begin
            cpuReq <= srcReq & ~claimed & ~dtceVec;
        end
    end

    // DMA path: each channel follows its selected flag independently
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dmaReq <= '0;
        end else begin
            for (int k = 0; k < NCHAN; k++) begin
                dmaReq[k] <= chanValid[k] & srcReq[chanSrc[k]];
            end
        end
    end

    // Flag clear pulses toward the sources
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            srcClear <= '0;
        end else begin
            srcClear <= next_srcClear;
        end
    end

    bus_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
        (read | write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait cycle");
    claim_blocks_cpu_a: assert property (@(posedge ref_clk) disable iff (rst)
        claimed[9] && srcReq[9] |=> !cpuReq[9])
        else $error("claimed source reached cpu");
    enable_blocks_cpu_a: assert property (@(posedge ref_clk) disable iff (rst)
        (srcReq & dtceVec & ~claimed) != '0 |=> (cpuReq & $past(dtceVec)) == '0)
        else $error("enabled source reached cpu");
    request_holds_a: assert property (@(posedge ref_clk) disable iff (rst)
        xferReq && !xferDone.done |=> xferReq && $stable(xferVector))
        else $error("transfer request dropped early");
    software_first_a: assert property (@(posedge ref_clk) disable iff (rst)
        state == router_pkg::XF_IDLE && swPending |=> xferReq && xferSoftware &&
        xferVector == router_pkg::VA_BASE + {8'h00, $past(swVector), 1'b0})
        else $error("software activation not first");
    enable_cleared_a: assert property (@(posedge ref_clk) disable iff (rst)
        enaClear |=> !dtceVec[$past(curSrc)] ##2 cpuReq[$past(curSrc, 3)] ||
        !srcReq[$past(curSrc, 3)])
        else $error("enable not cleared or cpu not told");
    unit_clears_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        flagClear && !router_pkg::PERIPH_CLR[curSrc] |=> srcClear[$past(curSrc)])
        else $error("flag not cleared after transfer");
    periph_owns_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (srcClear & router_pkg::PERIPH_CLR) == '0)
        else $error("peripheral flag cleared by router");
    dma_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        chanValid[0] && $stable(dmaCfg[0]) |=> dmaReq[0] == $past(srcReq[chanSrc[0]]))
        else $error("dma channel routed wrong source");
    no_cpu_during_a: assert property (@(posedge ref_clk) disable iff (rst)
        xferReq && !xferSoftware && $past(xferReq) |-> !cpuReq[curSrc])
        else $error("cpu saw source during transfer");

endmodule : interrupt_transfer_activation_router

// >>> sim/activation_partner.sv
// Far-side model: source flags, CPU handler, transfer unit and DMA channels.
// Assumes the router's outputs on ref_clk and flag set pulses from the bench.
`timescale 1ns/1ps
module activation_partner #(
    parameter int XFER_LAT = 3,
    parameter int DMA_LAT  = 2
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic [router_pkg::NSRC-1:0]  setSrc,
    input  wire logic [router_pkg::NSRC-1:0]  cpuServe,
    input  wire logic [router_pkg::NSRC-1:0]  cpuReq,
    input  wire logic [router_pkg::NSRC-1:0]  srcClear,
    output logic      [router_pkg::NSRC-1:0]  srcReq,
    input  wire logic                         xferReq,
    input  wire logic [15:0]                  xferVector,
    input  wire logic                         postIrq,
    input  wire logic                         countZero,
    output router_pkg::xfer_done_s            xferDone,
    input  wire logic [router_pkg::NCHAN-1:0] dmaReq,
    output logic      [router_pkg::NCHAN-1:0] dmaDone
);
    int                          xferCnt;
    int                          dmaCnt [router_pkg::NCHAN];
    logic [router_pkg::NSRC-1:0] periphHit;

    // Converter or serial flag whose data register the transfer touches
    always_comb begin
        for (int i = 0; i < router_pkg::NSRC; i++) begin
            periphHit[i] = router_pkg::PERIPH_CLR[i]
                && (xferVector[7:1] == router_pkg::VEC_NUM[i]);
        end
    end

    // Flags: set by bench, cleared by router, CPU handler or data access
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            srcReq <= '0;
        end else begin
            srcReq <= (srcReq | setSrc) & ~srcClear & ~(cpuReq & cpuServe)
                & ~(xferDone.done ? periphHit : '0);
        end
    end

    // Transfer unit: one completion per request, XFER_LAT cycles late
    always_ff @(posedge ref_clk) begin
        if (rst || !xferReq) begin
            xferCnt  <= 0;
            xferDone <= '0;
        end else begin
            xferDone <= {xferCnt == XFER_LAT, postIrq, countZero};
            if (xferCnt <= XFER_LAT) begin
                xferCnt <= xferCnt + 1;
            end
        end
    end

    // DMA channels: one completion per request, DMA_LAT cycles late
    always_ff @(posedge ref_clk) begin
        for (int k = 0; k < router_pkg::NCHAN; k++) begin
            if (rst || !dmaReq[k]) begin
                dmaCnt[k]  <= 0;
                dmaDone[k] <= 1'b0;
            end else begin
                dmaDone[k] <= (dmaCnt[k] == DMA_LAT);
                if (dmaCnt[k] <= DMA_LAT) begin
                    dmaCnt[k] <= dmaCnt[k] + 1;
                end
            end
        end
    end
endmodule : activation_partner

// >>> sim/interrupt_transfer_activation_router_test.sv
// Self-checking bench for the interrupt activation router.
// Assumes the far-side model and an Avalon-MM master made of tasks.
`timescale 1ns/1ps
module interrupt_transfer_activation_router_test;
    localparam logic [router_pkg::NSRC-1:0] ONE = 1;
    logic                         ref_clk, rst, read, write, waitrequest;
    logic                         xferReq, xferSoftware, postIrq, countZero;
    logic [7:0]                   address;
    logic [31:0]                  writedata, readdata, rdata;
    logic [15:0]                  xferVector;
    logic [router_pkg::NSRC-1:0]  srcReq, srcClear, cpuReq, setSrc, cpuServe;
    logic [router_pkg::NCHAN-1:0] dmaReq, dmaDone;
    router_pkg::xfer_done_s       xferDone;
    int                           mismatches, comparisons;

    interrupt_transfer_activation_router dut_u (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .srcReq(srcReq), .srcClear(srcClear), .cpuReq(cpuReq), .xferReq(xferReq),
        .xferVector(xferVector), .xferSoftware(xferSoftware), .xferDone(xferDone),
        .dmaReq(dmaReq), .dmaDone(dmaDone));
    activation_partner partner_u (
        .ref_clk(ref_clk), .rst(rst), .setSrc(setSrc), .cpuServe(cpuServe),
        .cpuReq(cpuReq), .srcClear(srcClear), .srcReq(srcReq), .xferReq(xferReq),
        .xferVector(xferVector), .postIrq(postIrq), .countZero(countZero),
        .xferDone(xferDone), .dmaReq(dmaReq), .dmaDone(dmaDone));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic giveUp(input string what);
        mismatches++;
        $display("CHECK FAILED %s expected answer seen none", what);
        tally_and_finish();
    endtask : giveUp

    task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : checkWord

    task automatic checkBit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit

    // One bus cycle, held until waitrequest is seen low
    task automatic busAccess(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        if (n == 20) giveUp("waitrequest");
        rdata = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : busAccess

    task automatic checkReg(input logic [7:0] a, input logic [31:0] exp);
        busAccess(1'b0, a, 32'h0);
        checkWord($sformatf("register %h", a), exp, rdata);
    endtask : checkReg

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cycles

    task automatic waitXfer(input logic lvl);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (xferReq === lvl) break;
        end
        if (n == 50) giveUp("xferReq");
    endtask : waitXfer

    task automatic pulse(input logic [router_pkg::NSRC-1:0] m);
        @(posedge ref_clk);
        setSrc <= m;
        @(posedge ref_clk);
        setSrc <= '0;
    endtask : pulse

    // CPU handler clears whatever it is offered
    task automatic serve;
        @(posedge ref_clk);
        cpuServe <= '1;
        cycles(4);
        cpuServe <= '0;
    endtask : serve

    task automatic runXfer(input int idx, input logic [15:0] vec, input logic [7:0] off,
                           input logic [7:0] ena, input logic p, input logic z);
        busAccess(1'b1, off, {24'h0, ena});
        postIrq   <= p;
        countZero <= z;
        pulse(ONE << idx);
        waitXfer(1'b1);
        checkWord("xferVector", {16'h0, vec}, {16'h0, xferVector});
        checkBit("cpuReq in transfer", 1'b0, cpuReq[idx]);
        waitXfer(1'b0);
        cycles(3);
        checkBit("cpuReq after transfer", p | z, cpuReq[idx]);
        checkBit("flag after transfer", p | z, srcReq[idx]);
        checkReg(off, (p | z) ? 32'h0 : {24'h0, ena});
        serve();
    endtask : runXfer

    // Main sequence
    initial begin
        {rst, read, write, address, writedata} = {1'b1, 42'h0};
        {setSrc, cpuServe, postIrq, countZero} = '0;
        mismatches  = 0;
        comparisons = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        checkReg(router_pkg::OFF_ENA, 32'h0);
        checkReg(router_pkg::OFF_DMACH, 32'h0);
        checkReg(8'hfc, 32'h0);
        busAccess(1'b1, router_pkg::OFF_STEP, 32'h7f);
        checkReg(router_pkg::OFF_STEP, 32'h7f);
        busAccess(1'b1, router_pkg::OFF_STEP, 32'h0);
        // Enable clear sends the source to the CPU
        pulse(ONE << 9);
        cycles(3);
        checkBit("cpuReq route", 1'b1, cpuReq[9]);
        checkBit("xferReq route", 1'b0, xferReq);
        serve();
        cycles(2);
        checkBit("cpuReq released", 1'b0, cpuReq[9]);
        runXfer(9, 16'h0440, router_pkg::OFF_STEP, 8'h20, 1'b0, 1'b0);
        runXfer(9, 16'h0440, router_pkg::OFF_STEP, 8'h20, 1'b1, 1'b0);
        runXfer(29, 16'h0490, 8'h10, 8'h80, 1'b0, 1'b1);
        // Converter and serial pending together
        countZero <= 1'b0;
        busAccess(1'b1, router_pkg::OFF_STEP, 32'h40);
        busAccess(1'b1, 8'h10, 32'h01);
        pulse((ONE << 8) | (ONE << 36));
        waitXfer(1'b1);
        checkWord("first vector", 32'h0438, {16'h0, xferVector});
        waitXfer(1'b0);
        waitXfer(1'b1);
        checkWord("second vector", 32'h04ac, {16'h0, xferVector});
        waitXfer(1'b0);
        cycles(3);
        checkBit("serial cpuReq", 1'b0, cpuReq[36]);
        busAccess(1'b1, router_pkg::OFF_STEP, 32'h0);
        busAccess(1'b1, 8'h10, 32'h0);
        // Software activation
        busAccess(1'b1, router_pkg::OFF_SWVEC, 32'h7f);
        waitXfer(1'b1);
        checkWord("software vector", 32'h04fe, {16'h0, xferVector});
        checkBit("xferSoftware", 1'b1, xferSoftware);
        waitXfer(1'b0);
        // DMA claims the source
        busAccess(1'b1, router_pkg::OFF_STEP, 32'h20);
        busAccess(1'b1, router_pkg::OFF_DMACH, 32'h12);
        checkReg(router_pkg::OFF_DMACH, 32'h12);
        pulse(ONE << 9);
        cycles(2);
        checkBit("dmaReq claimed", 1'b1, dmaReq[0]);
        checkBit("xferReq claimed", 1'b0, xferReq);
        checkBit("cpuReq claimed", 1'b0, cpuReq[9]);
        cycles(8);
        checkBit("flag cleared by DMA", 1'b0, srcReq[9]);
        // DMA without claim shares the source with the CPU
        busAccess(1'b1, router_pkg::OFF_STEP, 32'h0);
        busAccess(1'b1, router_pkg::OFF_DMACH, 32'h02);
        pulse(ONE << 9);
        cycles(8);
        checkBit("dmaReq shared", 1'b1, dmaReq[0]);
        checkBit("cpuReq shared", 1'b1, cpuReq[9]);
        checkBit("flag kept", 1'b1, srcReq[9]);
        serve();
        cycles(2);
        checkBit("dmaReq released", 1'b0, dmaReq[0]);
        tally_and_finish();
    end
endmodule : interrupt_transfer_activation_router_test
